/* File: dps_pkg.sv */
package dps_pkg;
  localparam int DW = 32;
  localparam int AW = 16;
  localparam int MODE_DEF_W = 8;
  // object addresses, printed offsets used directly
  localparam logic [15:0] ADR_FE_REACT = 16'h3700;
  localparam logic [15:0] ADR_HOLD = 16'h3212;
  localparam logic [15:0] ADR_MOTION = 16'h3f00;
  localparam logic [15:0] ADR_CTRL = 16'h6040;
  localparam logic [15:0] ADR_STAT = 16'h6041;
  localparam logic [15:0] ADR_QS = 16'h605a;
  localparam logic [15:0] ADR_SD = 16'h605b;
  localparam logic [15:0] ADR_DO = 16'h605c;
  localparam logic [15:0] ADR_HALT = 16'h605d;
  localparam logic [15:0] ADR_FLT = 16'h605e;
  localparam logic [15:0] ADR_MODE = 16'h6060;
  localparam logic [15:0] ADR_MODE_ACT = 16'h6061;
  localparam logic [15:0] ADR_FE_WIN = 16'h6065;
  // control word bit positions
  localparam int CB_SO = 0;
  localparam int CB_EV = 1;
  localparam int CB_QS = 2;
  localparam int CB_EO = 3;
  localparam int CB_FR = 7;
  localparam int CB_HALT = 8;
  // reset values, and the all-ones window value that turns following error monitoring off
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [15:0] REACT_RST = 16'h0001;
  localparam logic [31:0] FE_WIN_RST = 32'h0000_0100;
  localparam logic [31:0] FE_WIN_OFF = 32'hffff_ffff;
  // reaction option codes
  localparam logic [15:0] RC_IMM = 16'h0000;
  localparam logic [15:0] RC_SLOW = 16'h0001;
  localparam logic [15:0] RC_QUICK = 16'h0002;
  // operating modes in which halt acts
  localparam logic [7:0] MD_PP = 8'h01;
  localparam logic [7:0] MD_VL = 8'h02;
  localparam logic [7:0] MD_PV = 8'h03;
  localparam logic [7:0] MD_PT = 8'h04;
  localparam logic [7:0] MD_IP = 8'h07;
  // status word: relevant bits and per-state codes
  localparam logic [15:0] SW_MASK = 16'h006f;
  localparam logic [15:0] SW_NOT_READY = 16'h0000;
  localparam logic [15:0] SW_SO_DIS = 16'h0040;
  localparam logic [15:0] SW_READY = 16'h0021;
  localparam logic [15:0] SW_SW_ON = 16'h0023;
  localparam logic [15:0] SW_OP_EN = 16'h0027;
  localparam logic [15:0] SW_QSTOP = 16'h0007;
  localparam logic [15:0] SW_FLT_REACT = 16'h000f;
  localparam logic [15:0] SW_FAULT = 16'h0008;
  typedef enum logic [3:0] {
    ST_NOT_READY = 4'h0, ST_SO_DIS = 4'h1, ST_READY = 4'h2,
    ST_SW_ON = 4'h3, ST_OP_EN = 4'h4, ST_QSTOP = 4'h5,
    ST_FLT_REACT = 4'h6, ST_FAULT = 4'h7, ST_RAMP = 4'h8,
    ST_LOCKED = 4'h9
  } dps_state_t;
  typedef enum logic [1:0] {
    BK_NONE = 2'h0, BK_IMM = 2'h1, BK_SLOW = 2'h2, BK_QUICK = 2'h3
  } dps_brake_t;
  typedef enum logic [2:0] {
    CMD_NONE = 3'h0, CMD_SHUTDOWN = 3'h1, CMD_SWITCH_ON = 3'h2,
    CMD_DIS_VOLT = 3'h3, CMD_QSTOP = 3'h4, CMD_ENABLE = 3'h5
  } dps_cmd_t;
  typedef struct packed {
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic wr;
    logic rd;
  } dps_bus_req_t;
  typedef struct packed {
    dps_brake_t brake;
    logic torque;
    logic [MODE_DEF_W-1:0] mode;
  } dps_drive_t;
endpackage

/* File: dps_core.sv */
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps
// Functional notes
// - state changes only come from control word writes (plus device events)
// - status word always shows present state, readable any time
// - bit7 low: shutdown x110, switch-on/disable-op 0111, enable 1111
// - disable voltage is bit1 low; quick stop bit2 low, bit1 high
// - fault reset only on bit7 rising edge; leaves fault state
// - status bits 6,5,3..0 encode state per fixed masks
// - after power-up self-test passes, enter switch-on-disabled
// - holding torque in switched-on only when option written 1
// - requested mode takes effect on reaching operation enabled
// - mode writes accepted only in disabled, ready, switched-on states
// - unrecoverable error locks into not-ready, commands ignored
// - quick stop code 0 immediate and stays in quick stop; 1 slow, 2 quick, then disabled
// - shutdown code 0 immediate, 1 slow ramp then disabled
// - disable-operation code 0 immediate, 1 slow ramp then disabled
// - halt bit applies halt code: 1 slow, 2 quick ramp
// - halt acts only in PP, VL, PV, PT, IP modes
// - fault brakes per fault code 0 immediate, 1 slow, 2 quick
// - following error brakes per its own code
// - following error monitoring off while window is all ones
module dps_core
#(
  parameter int MODE_W = 8
)
(
  input wire logic clock_in,
  input wire logic rst_in,
  input wire dps_pkg::dps_bus_req_t bus_in,
  output logic [dps_pkg::DW-1:0] rdata_out,
  input wire logic selftest_done_in,
  input wire logic selftest_pass_in,
  input wire logic fault_in,
  input wire logic unrecoverable_in,
  input wire logic following_error_in,
  input wire logic brake_done_in,
  output dps_pkg::dps_drive_t drive_out,
  output logic [15:0] status_out
);
  import dps_pkg::*;

  // mode field must fit the drive carrier
  if (MODE_W < 1 || MODE_W > MODE_DEF_W)
  begin : g_bad
    $error("MODE_W out of range");
  end
  dps_state_t state;
  dps_state_t next_state;
  dps_brake_t brake;
  dps_brake_t next_brake;
  dps_cmd_t cmd;
  logic [15:0] ctrl;
  logic [15:0] qs_code;
  logic [15:0] sd_code;
  logic [15:0] do_code;
  logic [15:0] halt_code;
  logic [15:0] flt_code;
  logic [15:0] fe_code;
  logic [31:0] fe_win;
  logic hold_opt;
  logic [MODE_W-1:0] mode_req;
  logic [MODE_W-1:0] mode_act;
  logic wr_ctrl;
  logic fr_edge;
  logic fe_event;
  logic mode_open;
  logic halt_on;
  dps_brake_t halt_brake;
  logic [DW-1:0] rd_val;

  // command decode, bit7 high carries no command
  function automatic dps_cmd_t decode(input logic [15:0] w);
    if (w[CB_FR])
      return CMD_NONE;
    else if (!w[CB_EV])
      return CMD_DIS_VOLT;
    else if (!w[CB_QS])
      return CMD_QSTOP;
    else if (!w[CB_SO])
      return CMD_SHUTDOWN;
    else if (!w[CB_EO])
      return CMD_SWITCH_ON;
    else
      return CMD_ENABLE;
  endfunction
  // reserved codes fall back to immediate stop, the safe choice
  function automatic dps_brake_t react(input logic [15:0] c,
                                       input logic quick_ok);
    if (c == RC_SLOW)
      return BK_SLOW;
    else if (c == RC_QUICK && quick_ok)
      return BK_QUICK;
    else
      return BK_IMM;
  endfunction
  // status word code for a state
  function automatic logic [15:0] encode(input dps_state_t s);
    unique case (s)
      ST_NOT_READY, ST_LOCKED: return SW_NOT_READY;
      ST_SO_DIS: return SW_SO_DIS;
      ST_READY: return SW_READY;
      ST_SW_ON, ST_RAMP: return SW_SW_ON;
      ST_OP_EN: return SW_OP_EN;
      ST_QSTOP: return SW_QSTOP;
      ST_FLT_REACT: return SW_FLT_REACT;
      ST_FAULT: return SW_FAULT;
      default: return SW_NOT_READY;
    endcase
  endfunction
  // write strobe and fault-reset edge against the stored bit7
  assign wr_ctrl = bus_in.wr && bus_in.addr == ADR_CTRL;
  assign fr_edge = wr_ctrl && bus_in.wdata[CB_FR] && !ctrl[CB_FR];
  assign cmd = wr_ctrl ? decode(bus_in.wdata[15:0]) : CMD_NONE;
  assign fe_event = following_error_in && fe_win != FE_WIN_OFF;
  assign mode_open = state == ST_SO_DIS || state == ST_READY ||
                     state == ST_SW_ON;
  // control word store
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
      ctrl <= CTRL_RST;
    else if (wr_ctrl)
      ctrl <= bus_in.wdata[15:0];
  end
  // option codes and monitoring window
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      qs_code <= REACT_RST;
      sd_code <= REACT_RST;
      do_code <= REACT_RST;
      halt_code <= REACT_RST;
      flt_code <= REACT_RST;
      fe_code <= REACT_RST;
      fe_win <= FE_WIN_RST;
      hold_opt <= 1'b0;
    end
    else if (bus_in.wr)
    begin
      unique case (bus_in.addr)
        ADR_QS: qs_code <= bus_in.wdata[15:0];
        ADR_SD: sd_code <= bus_in.wdata[15:0];
        ADR_DO: do_code <= bus_in.wdata[15:0];
        ADR_HALT: halt_code <= bus_in.wdata[15:0];
        ADR_FLT: flt_code <= bus_in.wdata[15:0];
        ADR_FE_REACT: fe_code <= bus_in.wdata[15:0];
        ADR_FE_WIN: fe_win <= bus_in.wdata;
        ADR_HOLD: hold_opt <= bus_in.wdata[0] &&
                              bus_in.wdata[15:1] == 15'h0000;
        default: ;
      endcase
    end
  end
  // requested mode, refused while running
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
      mode_req <= '0;
    else if (bus_in.wr && bus_in.addr == ADR_MODE && mode_open)
      mode_req <= bus_in.wdata[MODE_W-1:0];
  end
  // active mode only follows on entry to operation enabled
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
      mode_act <= '0;
    else if (next_state == ST_OP_EN && state != ST_OP_EN)
      mode_act <= mode_req;
  end

  // power state graph; device events outrank commands
  always_comb
  begin
    next_state = state;
    if (state == ST_QSTOP || state == ST_RAMP || state == ST_FLT_REACT)
      next_brake = brake;
    else
      next_brake = BK_NONE;
    unique case (state)
      ST_NOT_READY:
        if (selftest_done_in)
          next_state = selftest_pass_in ? ST_SO_DIS : ST_LOCKED;
      ST_LOCKED: ;
      ST_SO_DIS:
        if (cmd == CMD_SHUTDOWN)
          next_state = ST_READY;
      ST_READY:
        if (cmd == CMD_SWITCH_ON)
          next_state = ST_SW_ON;
        else if (cmd == CMD_DIS_VOLT || cmd == CMD_QSTOP)
          next_state = ST_SO_DIS;
      ST_SW_ON:
        if (cmd == CMD_ENABLE)
          next_state = ST_OP_EN;
        else if (cmd == CMD_SHUTDOWN)
          next_state = ST_READY;
        else if (cmd == CMD_DIS_VOLT || cmd == CMD_QSTOP)
          next_state = ST_SO_DIS;
      ST_OP_EN:
        if (cmd == CMD_SWITCH_ON)
        begin
          next_brake = react(do_code, 1'b0);
          next_state = next_brake == BK_IMM ? ST_SW_ON : ST_RAMP;
        end
        else if (cmd == CMD_SHUTDOWN)
        begin
          next_brake = react(sd_code, 1'b0);
          next_state = next_brake == BK_IMM ? ST_READY : ST_RAMP;
        end
        else if (cmd == CMD_DIS_VOLT)
        begin
          next_brake = BK_IMM;
          next_state = ST_SO_DIS;
        end
        else if (cmd == CMD_QSTOP)
        begin
          next_brake = react(qs_code, 1'b1);
          next_state = ST_QSTOP;
        end
      ST_QSTOP:
        if (cmd == CMD_DIS_VOLT)
          next_state = ST_SO_DIS;
        else if (brake != BK_IMM && brake_done_in)
          next_state = ST_SO_DIS;
      ST_RAMP:
        if (cmd == CMD_DIS_VOLT || brake_done_in)
          next_state = ST_SO_DIS;
      ST_FLT_REACT:
        if (brake == BK_IMM || brake_done_in)
          next_state = ST_FAULT;
      ST_FAULT:
        if (fr_edge)
          next_state = ST_SO_DIS;
      default:
        next_state = ST_LOCKED;
    endcase
    // events that override any command in the same cycle
    if (state != ST_NOT_READY && state != ST_LOCKED &&
        state != ST_FLT_REACT && state != ST_FAULT)
    begin
      if (fault_in)
      begin
        next_brake = react(flt_code, 1'b1);
        next_state = ST_FLT_REACT;
      end
      else if (fe_event && (state == ST_OP_EN || state == ST_QSTOP ||
               state == ST_RAMP))
      begin
        next_brake = react(fe_code, 1'b1);
        next_state = ST_FLT_REACT;
      end
    end
    if (unrecoverable_in)
    begin
      next_brake = BK_IMM;
      next_state = ST_LOCKED;
    end
  end
  // state register
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
      state <= ST_NOT_READY;
    else
      state <= next_state;
  end
  // braking request; immediate stop is a one-cycle pulse, two cycles after fault reaction, and holds in quick stop
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
      brake <= BK_NONE;
    else
      brake <= next_brake;
  end
  // halt only while running and in a mode that supports it
  always_comb
  begin
    halt_on = 1'b0;
    halt_brake = BK_NONE;
    if (mode_act == MODE_W'(MD_PP) || mode_act == MODE_W'(MD_VL) ||
        mode_act == MODE_W'(MD_PV) || mode_act == MODE_W'(MD_PT) ||
        mode_act == MODE_W'(MD_IP))
      halt_on = state == ST_OP_EN && ctrl[CB_HALT];
    if (halt_on && halt_code == RC_SLOW)
      halt_brake = BK_SLOW;
    else if (halt_on && halt_code == RC_QUICK)
      halt_brake = BK_QUICK;
  end
  // drive outputs; torque held in switched-on only by option
  always_comb
  begin
    drive_out = '0;
    drive_out.brake = halt_brake != BK_NONE ? halt_brake : brake;
    drive_out.torque = state == ST_OP_EN || state == ST_QSTOP ||
                       state == ST_RAMP || state == ST_FLT_REACT ||
                       (state == ST_SW_ON && hold_opt);
    drive_out.mode = MODE_DEF_W'(mode_act);
  end

  assign status_out = encode(state);

  // read mux; unmapped addresses read zero
  always_comb
  begin
    rd_val = '0;
    unique case (bus_in.addr)
      ADR_CTRL: rd_val = {16'h0000, ctrl};
      ADR_STAT: rd_val = {16'h0000, status_out};
      ADR_QS: rd_val = {16'h0000, qs_code};
      ADR_SD: rd_val = {16'h0000, sd_code};
      ADR_DO: rd_val = {16'h0000, do_code};
      ADR_HALT: rd_val = {16'h0000, halt_code};
      ADR_FLT: rd_val = {16'h0000, flt_code};
      ADR_FE_REACT: rd_val = {16'h0000, fe_code};
      ADR_FE_WIN: rd_val = fe_win;
      ADR_HOLD: rd_val = {31'h0000_0000, hold_opt};
      ADR_MODE: rd_val = DW'(mode_req);
      ADR_MODE_ACT: rd_val = DW'(mode_act);
      ADR_MOTION: rd_val = {28'h000_0000, halt_on, state == ST_LOCKED,
                            drive_out.brake};
      default: rd_val = '0;
    endcase
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
      rdata_out <= '0;
    else
      rdata_out <= bus_in.rd ? rd_val : '0;
  end

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);

  logic quiet;
  assign quiet = !fault_in && !following_error_in && !unrecoverable_in;

  AST_FR_EDGE: assert property (state == ST_FAULT && fr_edge && quiet
    |=> state == ST_SO_DIS)
    else $error("fault reset edge did not leave fault");
  AST_FR_LEVEL: assert property (state == ST_FAULT && wr_ctrl &&
    ctrl[CB_FR] && !unrecoverable_in |=> state == ST_FAULT)
    else $error("static bit7 repeated fault reset");
  AST_LOCKED: assert property (state == ST_LOCKED |=>
    state == ST_LOCKED && (status_out & SW_MASK) == SW_NOT_READY)
    else $error("locked state was left");
  AST_STAT_OP: assert property (state == ST_OP_EN |->
    (status_out & SW_MASK) == SW_OP_EN)
    else $error("wrong status for operation enabled");
  AST_STAT_QS: assert property (state == ST_QSTOP |->
    (status_out & SW_MASK) == SW_QSTOP)
    else $error("wrong status for quick stop");
  AST_NO_CMD: assert property ((state == ST_SO_DIS || state == ST_READY
    || state == ST_SW_ON || state == ST_OP_EN) && !wr_ctrl && quiet
    |=> $stable(state))
    else $error("state changed without a command");
  AST_SWON_FROM: assert property (state == ST_SW_ON &&
    $past(state) != ST_SW_ON && !$past(rst_in) |->
    $past(state) == ST_READY || $past(state) == ST_OP_EN)
    else $error("switched on entered from a wrong state");
  AST_MODE_REF: assert property (state == ST_OP_EN && bus_in.wr &&
    bus_in.addr == ADR_MODE |=> $stable(mode_req))
    else $error("mode changed while operation enabled");
  AST_MODE_ACT: assert property (state == ST_OP_EN |->
    mode_act == mode_req)
    else $error("active mode differs from request");
  AST_HOLD: assert property (state == ST_SW_ON |->
    drive_out.torque == hold_opt)
    else $error("holding torque does not follow option");
  AST_FRA_OUT: assert property (state == ST_FLT_REACT && brake_done_in
    && !unrecoverable_in |=> state == ST_FAULT)
    else $error("fault reaction did not end in fault");
  AST_FE_OFF: assert property (state == ST_OP_EN && fe_win == FE_WIN_OFF
    && following_error_in && !fault_in && !unrecoverable_in && !wr_ctrl
    |=> state == ST_OP_EN)
    else $error("following error acted while disabled");
  AST_QS_CODE: assert property (state == ST_OP_EN && cmd == CMD_QSTOP
    && quiet |=> state == ST_QSTOP && brake == react(qs_code, 1'b1))
    else $error("quick stop reaction code not applied");
  AST_ST_PASS: assert property (state == ST_NOT_READY &&
    selftest_done_in && selftest_pass_in && !unrecoverable_in
    |=> state == ST_SO_DIS)
    else $error("self-test pass did not reach disabled");

  COV_ENABLE: cover property (state == ST_SW_ON ##1 state == ST_OP_EN);
  COV_QSTOP_DONE: cover property (state == ST_QSTOP ##[1:20]
    state == ST_SO_DIS);
  COV_FAULT_RST: cover property (state == ST_FAULT ##[1:20]
    state == ST_SO_DIS);
  COV_HALT: cover property (halt_on && halt_brake == BK_QUICK);
endmodule

/* File: dps_motion_model.sv */
`timescale 1ns/1ps
// motion stage stand-in: reports standstill a while after a ramp starts
module dps_motion_model
#(
  parameter int RAMP_CYC = 8
)
(
  input wire logic clock_in,
  input wire logic rst_in,
  input wire dps_pkg::dps_brake_t brake_in,
  output logic brake_done_out
);
  import dps_pkg::*;
  logic [7:0] cnt;
  // done stays up until the ramp request goes away, like a real stage
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      cnt <= 8'h00;
      brake_done_out <= 1'b0;
    end
    else if (brake_in == BK_SLOW || brake_in == BK_QUICK)
    begin
      if (cnt == RAMP_CYC[7:0])
        brake_done_out <= 1'b1;
      else
        cnt <= cnt + 8'h01;
    end
    else
    begin
      cnt <= 8'h00;
      brake_done_out <= 1'b0;
    end
  end
endmodule

/* File: drive_power_state_machine_tb_top.sv */
`timescale 1ns/1ps
module drive_power_state_machine_tb_top;
  import dps_pkg::*;
  typedef struct {string name; logic [31:0] exp;
    logic [31:0] mask;} dps_note_t;
  typedef struct {logic [15:0] a; logic [15:0] c; logic [15:0] cmd;
    logic [15:0] s1; logic [2:0] b; logic [15:0] s2;} dps_row_t;
  logic clock_in, rst_in, st_done, st_pass, fault, unrec, ferr, bdone;
  logic probe, rd_seen, prb_seen;
  dps_bus_req_t bus;
  logic [DW-1:0] rdata;
  dps_drive_t drv;
  logic [15:0] status;
  dps_note_t notes[$];
  dps_note_t n;
  int num_errors, compares, cycles;
  logic [15:0] reacts[6] = '{ADR_QS, ADR_SD, ADR_DO, ADR_HALT, ADR_FLT,
    ADR_FE_REACT};
  // exit reactions: b of 4 means the brake pulse is too short to read
  dps_row_t rows[8] = '{
    '{ADR_QS, 16'h0, 16'h000b, SW_QSTOP, 3'h1, SW_QSTOP},
    '{ADR_QS, 16'h1, 16'h000b, SW_QSTOP, 3'h2, SW_SO_DIS},
    '{ADR_QS, 16'h2, 16'h000b, SW_QSTOP, 3'h3, SW_SO_DIS},
    '{ADR_QS, 16'h3, 16'h000b, SW_QSTOP, 3'h1, SW_QSTOP},
    '{ADR_SD, 16'h0, 16'h0006, SW_READY, 3'h4, SW_READY},
    '{ADR_SD, 16'h1, 16'h0006, SW_SW_ON, 3'h2, SW_SO_DIS},
    '{ADR_DO, 16'h0, 16'h0007, SW_SW_ON, 3'h4, SW_SW_ON},
    '{ADR_DO, 16'h1, 16'h0007, SW_SW_ON, 3'h2, SW_SO_DIS}};

  dps_core #(.MODE_W(8)) dps_core_inst (.clock_in(clock_in),
    .rst_in(rst_in), .bus_in(bus), .rdata_out(rdata),
    .selftest_done_in(st_done), .selftest_pass_in(st_pass),
    .fault_in(fault), .unrecoverable_in(unrec),
    .following_error_in(ferr), .brake_done_in(bdone),
    .drive_out(drv), .status_out(status));
  dps_motion_model dps_motion_model_inst (.clock_in(clock_in),
    .rst_in(rst_in), .brake_in(drv.brake), .brake_done_out(bdone));

  initial
  begin
    clock_in = 1'b0;
    forever #50 clock_in = ~clock_in;
  end

  task automatic check(input string nm, input logic [31:0] seen,
    input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge clock_in);
    bus.addr <= a;
    bus.wdata <= d;
    bus.wr <= 1'b1;
    @(posedge clock_in);
    bus.wr <= 1'b0;
  endtask

  task automatic rd_chk(input string nm, input logic [15:0] a,
    input logic [31:0] e, input logic [31:0] m);
    notes.push_back('{nm, e, m});
    @(posedge clock_in);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge clock_in);
    bus.rd <= 1'b0;
  endtask

  task automatic st(input logic [15:0] e);
    rd_chk("status", ADR_STAT, {16'h0, e}, {16'h0, SW_MASK});
  endtask

  task automatic bk(input logic [2:0] e);
    if (e < 3'h4)
      rd_chk("brake", ADR_MOTION, {29'h0, e}, 32'h3);
  endtask

  // active mode is 6 by then, latched since the halt-scope test
  task automatic probe_torque(input logic e);
    notes.push_back('{"torque and mode", {23'h0, e, 8'h06}, 32'h1ff});
    @(posedge clock_in);
    probe <= 1'b1;
    @(posedge clock_in);
    probe <= 1'b0;
  endtask

  // one-cycle event: 0 fault, 1 following error, 2 unrecoverable
  task automatic pulse(input int k);
    @(posedge clock_in);
    fault <= k == 0;
    ferr <= k == 1;
    unrec <= k == 2;
    @(posedge clock_in);
    {fault, ferr, unrec} <= 3'h0;
  endtask

  // don't-care command bits get random values, halt and reset bits stay 0
  task automatic to_op();
    wr(ADR_CTRL, 32'h0006 | ($urandom & 32'hfe78));
    st(SW_READY);
    wr(ADR_CTRL, 32'h0007 | ($urandom & 32'hfe70));
    st(SW_SW_ON);
    wr(ADR_CTRL, 32'h000f | ($urandom & 32'hfe70));
    st(SW_OP_EN);
  endtask

  // sample strobes at the edge, compare once read data has settled
  always @(posedge clock_in)
  begin
    rd_seen <= bus.rd;
    prb_seen <= probe;
  end
  always @(negedge clock_in)
  begin
    if (rd_seen || prb_seen)
    begin
      if (notes.size() == 0)
        check("note", 32'h0, 32'h1);
      else
      begin
        n = notes.pop_front();
        check(n.name, (rd_seen ? rdata : {23'h0, drv.torque, drv.mode})
          & n.mask, n.exp);
      end
    end
    else
      check("idle read data", rdata, 32'h0);
  end

  always @(posedge clock_in)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      num_errors++;
      summarize();
    end
  end

  initial
  begin
    {st_done, st_pass, fault, unrec, ferr, probe} = 6'h00;
    bus = '0;
    rst_in = 1'b1;
    void'($urandom(55));
    repeat (2) @(posedge clock_in);
    rst_in <= 1'b0;
    // reset values, read-only status, unmapped place
    st(SW_NOT_READY);
    rd_chk("ctrl", ADR_CTRL, 32'h0, 32'hffff);
    foreach (reacts[i])
      rd_chk("reaction", reacts[i], 32'h1, 32'hffff);
    rd_chk("window", ADR_FE_WIN, FE_WIN_RST, 32'hffffffff);
    rd_chk("unmapped", 16'h1234, 32'h0, 32'hffffffff);
    wr(ADR_STAT, 32'h0027);
    wr(ADR_CTRL, 32'h0006);
    st(SW_NOT_READY);
    $display("test reset done");
    @(posedge clock_in);
    st_done <= 1'b1;
    st_pass <= 1'b1;
    st(SW_SO_DIS);
    wr(ADR_CTRL, 32'h000f);
    st(SW_SO_DIS);
    $display("test selftest done");
    // mode gating and halt
    wr(ADR_MODE, 32'h3);
    to_op();
    rd_chk("mode_act", ADR_MODE_ACT, 32'h3, 32'hff);
    wr(ADR_MODE, 32'h1);
    rd_chk("mode", ADR_MODE, 32'h3, 32'hff);
    wr(ADR_HALT, 32'h2);
    wr(ADR_CTRL, 32'h010f);
    bk(3'h3);
    wr(ADR_HALT, 32'h1);
    bk(3'h2);
    wr(ADR_CTRL, 32'h0000);
    st(SW_SO_DIS);
    // mode 6 is outside the halt set, so the halt bit must do nothing
    wr(ADR_MODE, 32'h6);
    to_op();
    wr(ADR_CTRL, 32'h010f);
    bk(3'h0);
    wr(ADR_CTRL, 32'h0000);
    st(SW_SO_DIS);
    $display("test mode and halt done");
    // every exit reaction code
    foreach (rows[i])
    begin
      wr(rows[i].a, {16'h0, rows[i].c});
      to_op();
      wr(ADR_CTRL, {16'h0, rows[i].cmd});
      st(rows[i].s1);
      bk(rows[i].b);
      repeat (16) @(posedge clock_in);
      st(rows[i].s2);
      wr(ADR_CTRL, 32'h0000);
      st(SW_SO_DIS);
    end
    $display("test exit reactions done");
    wr(ADR_CTRL, 32'h0006);
    wr(ADR_CTRL, 32'h0007);
    probe_torque(1'b0);
    wr(ADR_HOLD, 32'h1);
    probe_torque(1'b1);
    wr(ADR_CTRL, 32'h0000);
    $display("test holding torque done");
    // fault reaction, automatic fault entry, edge-only reset
    wr(ADR_FLT, 32'h1);
    to_op();
    pulse(0);
    st(SW_FLT_REACT);
    bk(3'h2);
    repeat (16) @(posedge clock_in);
    st(SW_FAULT);
    wr(ADR_CTRL, 32'h0080);
    st(SW_SO_DIS);
    wr(ADR_FLT, 32'h0);
    pulse(0);
    st(SW_FAULT);
    wr(ADR_CTRL, 32'h0080);
    st(SW_FAULT);
    wr(ADR_CTRL, 32'h0000);
    wr(ADR_CTRL, 32'h0080);
    st(SW_SO_DIS);
    $display("test fault done");
    // following error, off while window is all ones
    wr(ADR_FE_WIN, FE_WIN_OFF);
    to_op();
    pulse(1);
    st(SW_OP_EN);
    wr(ADR_FE_WIN, FE_WIN_RST);
    wr(ADR_FE_REACT, 32'h2);
    pulse(1);
    st(SW_FLT_REACT);
    bk(3'h3);
    $display("test following error done");
    pulse(2);
    st(SW_NOT_READY);
    wr(ADR_CTRL, 32'h0000);
    wr(ADR_CTRL, 32'h0080);
    st(SW_NOT_READY);
    $display("test unrecoverable done");
    repeat (3) @(posedge clock_in);
    if (notes.size() != 0)
      num_errors++;
    summarize();
  end
endmodule
